// [rtl/mmps_pkg.sv]
// constants and types of the management paging and sideband block
package mmps_pkg;
	localparam int          MMPS_PAGE_BYTES = 128;
	localparam int          MMPS_SLOTS      = 6;
	localparam logic [7:0]  MMPS_ADDR_BANK  = 8'h7e;
	localparam logic [7:0]  MMPS_ADDR_PAGE  = 8'h7f;
	localparam logic [7:0]  MMPS_PG_00      = 8'h00;
	localparam logic [7:0]  MMPS_PG_01      = 8'h01;
	localparam logic [7:0]  MMPS_PG_02      = 8'h02;
	localparam logic [7:0]  MMPS_PG_10      = 8'h10;
	localparam logic [7:0]  MMPS_PG_11      = 8'h11;
	localparam logic [7:0]  MMPS_PG_LANE_HI = 8'h1f;
	localparam logic [7:0]  MMPS_PAGE_RST   = 8'h00;
	localparam logic [7:0]  MMPS_BANK_RST   = 8'h00;
	localparam logic [11:0] MMPS_MEM_TOP    = 12'h3fc;
	localparam logic [11:0] MMPS_REG_SIDE   = 12'h400;
	localparam logic [11:0] MMPS_REG_STAT   = 12'h404;
	localparam logic [11:0] MMPS_REG_MASK   = 12'h408;
	localparam logic [11:0] MMPS_REG_CTRL   = 12'h40c;
	localparam int          MMPS_IRQ_W      = 4;
	localparam int          MMPS_EV_RST_REL = 0;
	localparam int          MMPS_EV_LP_CHG  = 1;
	localparam int          MMPS_EV_SEL_WR  = 2;
	localparam int          MMPS_EV_BAD_PG  = 3;
	localparam logic [1:0]  MMPS_RESP_OKAY  = 2'h0;
	localparam logic [1:0]  MMPS_RESP_SLVE  = 2'h2;

	typedef struct packed {
		logic reset_n;
		logic lowpower_n;
		logic irq_drive;
		logic rst_release;
		logic lp_change;
	} mmps_side_t;

	typedef struct packed {
		logic       valid;
		logic [2:0] slot;
	} mmps_slot_t;

	typedef enum logic [1:0] {
		MMPS_W_IDLE = 2'h1,
		MMPS_W_RESP = 2'h2
	} mmps_wst_t;

	typedef enum logic [2:0] {
		MMPS_R_IDLE = 3'h1,
		MMPS_R_DATA = 3'h2,
		MMPS_R_RESP = 3'h4
	} mmps_rst_t;

	// which stored page instance the selection shows in upper memory
	function automatic mmps_slot_t mmps_slot(input logic [7:0] page, input logic [7:0] bank);
		mmps_slot_t s;
		s = '{valid: 1'b1, slot: 3'h0};
		case (page)
			MMPS_PG_00: s.slot = 3'h1;
			MMPS_PG_01: s.slot = 3'h2;
			MMPS_PG_02: s.slot = 3'h3;
			MMPS_PG_10: begin
				s.slot  = 3'h4;
				s.valid = (bank == 8'h00);
			end
			MMPS_PG_11: begin
				s.slot  = 3'h5;
				s.valid = (bank == 8'h00);
			end
			default: s.valid = 1'b0;
		endcase
		return s;
	endfunction
endpackage

// [rtl/mmps_sideband.sv]
// decode of the two multi-level sideband lines
`timescale 1ns/1ps
module mmps_sideband
	import mmps_pkg::*;
(
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       rst_line_above,
	input  wire logic       lp_line_above,
	input  wire logic       irq_request,
	output mmps_side_t      side
);
	logic rst_q, rst_d, lp_q, lp_d, drv_q, drv_d, rel_q, rel_d, chg_q, chg_d;

	always_comb begin
		// line below threshold holds module in reset
		rst_d = rst_line_above;
		lp_d  = lp_line_above;
		// interrupt only while out of reset
		drv_d = irq_request & rst_line_above & rst_q;
		rel_d = rst_line_above & ~rst_q;
		chg_d = lp_line_above ^ lp_q;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rst_q <= 1'b0;
			lp_q  <= 1'b0;
			drv_q <= 1'b0;
			rel_q <= 1'b0;
			chg_q <= 1'b0;
		end else begin
			rst_q <= rst_d;
			lp_q  <= lp_d;
			drv_q <= drv_d;
			rel_q <= rel_d;
			chg_q <= chg_d;
		end
	end

	assign side = '{reset_n: rst_q, lowpower_n: lp_q, irq_drive: drv_q, rst_release: rel_q, lp_change: chg_q};
endmodule

// [rtl/mmps_page_mem.sv]
// byte store for lower memory and implemented upper pages
`timescale 1ns/1ps
module mmps_page_mem #(
	parameter int DEPTH = 768,
	parameter int AW    = 10
) (
	input  wire logic          aclk,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [7:0]    wr_data,
	input  wire logic [AW-1:0] rd_addr,
	output logic [7:0]         rd_data_q
);
	logic [7:0] mem [DEPTH];

	always_ff @(posedge aclk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data_q <= mem[rd_addr];
	end
endmodule

// [rtl/mmps_top.sv]
// management memory with paging and sideband decode behind axi4-lite
// Notes on behaviour
// - lowest reset zone holds module, no interrupt
// - middle zone runs module, no interrupt
// - interrupt raised only out of reset
// - reset and interrupt keep their polarities
// - low-power request seen active low
// - presence shown by constant pull-down
// - lowest low-power zone enters low power
// - middle low-power zone allows full power
// - single-byte addressing, 256-byte window
// - 00h-7Fh lower, 80h-FFh selected page
// - lower always visible, one upper page
// - bank chooses instance of lane pages
// - lower memory and page zero always present
// - pages 01h, 02h, 10h/11h bank zero present
// - bank zero of 10h-1Fh covers lanes 1-8; only 10h and 11h are stored, 12h-1Fh read as zero
//
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module mmps_top
	import mmps_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        irq_reset_shared_line_i,
	output logic             irq_reset_shared_line_o,
	output logic             irq_reset_shared_line_oe,
	input  wire logic        lowpower_present_shared_line_i,
	output logic             lowpower_present_shared_line_o,
	output logic             lowpower_present_shared_line_oe,
	output logic             module_side_reset_n,
	output logic             module_side_lowpower_n,
	output logic             irq_o
);
	mmps_side_t            side;
	mmps_wst_t             wst_q, wst_d;
	mmps_rst_t             rst_q, rst_d;
	logic [11:0]           awaddr_q, awaddr_d, araddr_q, araddr_d;
	logic [7:0]            wbyte_q, wbyte_d;
	logic                  aw_have_q, aw_have_d, w_have_q, w_have_d, wlane_q, wlane_d;
	logic [1:0]            bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0]           rdata_q, rdata_d;
	logic [7:0]            page_q, page_d, bank_q, bank_d;
	logic [MMPS_IRQ_W-1:0] stat_q, stat_d, mask_q, mask_d, ev;
	logic                  hreq_q, hreq_d;
	logic                  do_wr, mem_we;
	logic [9:0]            mem_waddr, mem_raddr;
	logic [7:0]            mem_rdata;
	mmps_slot_t            wslot, rslot;
	logic                  rd_bad;

	mmps_sideband u_side (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.rst_line_above(irq_reset_shared_line_i),
		.lp_line_above (lowpower_present_shared_line_i),
		.irq_request   (hreq_q),
		.side          (side)
	);

	// active-low reset and active-high interrupt kept as such
	assign module_side_reset_n    = side.reset_n;
	assign module_side_lowpower_n = side.lowpower_n;
	// line lifted to top zone only when driving interrupt
	assign irq_reset_shared_line_o  = 1'b1;
	assign irq_reset_shared_line_oe = side.irq_drive;
	assign lowpower_present_shared_line_o  = 1'b0;
	assign lowpower_present_shared_line_oe = 1'b1;

	mmps_page_mem #(
		.DEPTH(MMPS_SLOTS * MMPS_PAGE_BYTES),
		.AW   (10)
	) u_mem (
		.aclk     (aclk),
		.wr_en    (mem_we),
		.wr_addr  (mem_waddr),
		.wr_data  (wbyte_q),
		.rd_addr  (mem_raddr),
		.rd_data_q(mem_rdata)
	);

	// page and bank select the stored instance
	assign wslot = mmps_slot(page_q, bank_q);
	assign rslot = mmps_slot(page_q, bank_q);

	// word index bits give the 8-bit management address
	// bit 7 chooses lower memory or the selected page
	assign mem_waddr = awaddr_q[9] ? {wslot.slot, awaddr_q[8:2]} : {3'h0, awaddr_q[8:2]};
	assign mem_raddr = s_axi_araddr[9] ? {rslot.slot, s_axi_araddr[8:2]} : {3'h0, s_axi_araddr[8:2]};

	assign do_wr  = (wst_q == MMPS_W_IDLE) && aw_have_q && w_have_q;
	// unsupported page or bank writes are dropped
	assign mem_we = do_wr && wlane_q && (awaddr_q <= MMPS_MEM_TOP) && (!awaddr_q[9] || wslot.valid);
	assign rd_bad = araddr_q[9] && !rslot.valid && (araddr_q <= MMPS_MEM_TOP);

	// write channel
	always_comb begin
		wst_d     = wst_q;
		aw_have_d = aw_have_q;
		w_have_d  = w_have_q;
		awaddr_d  = awaddr_q;
		wbyte_d   = wbyte_q;
		wlane_d   = wlane_q;
		bresp_d   = bresp_q;
		case (wst_q)
			MMPS_W_IDLE: begin
				if (s_axi_awvalid && s_axi_awready) begin
					aw_have_d = 1'b1;
					awaddr_d  = s_axi_awaddr;
				end
				if (s_axi_wvalid && s_axi_wready) begin
					w_have_d = 1'b1;
					wbyte_d  = s_axi_wdata[7:0];
					wlane_d  = s_axi_wstrb[0];
				end
				if (do_wr) begin
					aw_have_d = 1'b0;
					w_have_d  = 1'b0;
					bresp_d   = (awaddr_q <= MMPS_REG_CTRL) ? MMPS_RESP_OKAY : MMPS_RESP_SLVE;
					wst_d     = MMPS_W_RESP;
				end
			end
			MMPS_W_RESP: begin
				if (s_axi_bready) begin
					wst_d = MMPS_W_IDLE;
				end
			end
			default: wst_d = MMPS_W_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wst_q     <= MMPS_W_IDLE;
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			awaddr_q  <= 12'h000;
			wbyte_q   <= 8'h00;
			wlane_q   <= 1'b0;
			bresp_q   <= MMPS_RESP_OKAY;
		end else begin
			wst_q     <= wst_d;
			aw_have_q <= aw_have_d;
			w_have_q  <= w_have_d;
			awaddr_q  <= awaddr_d;
			wbyte_q   <= wbyte_d;
			wlane_q   <= wlane_d;
			bresp_q   <= bresp_d;
		end
	end

	assign s_axi_awready = (wst_q == MMPS_W_IDLE) && !aw_have_q;
	assign s_axi_wready  = (wst_q == MMPS_W_IDLE) && !w_have_q;
	assign s_axi_bvalid  = (wst_q == MMPS_W_RESP);
	assign s_axi_bresp   = bresp_q;

	// control, selection and interrupt state
	always_comb begin
		page_d = page_q;
		bank_d = bank_q;
		mask_d = mask_q;
		hreq_d = hreq_q;
		ev     = '0;
		ev[MMPS_EV_RST_REL] = side.rst_release;
		ev[MMPS_EV_LP_CHG]  = side.lp_change;
		ev[MMPS_EV_BAD_PG]  = (rst_q == MMPS_R_DATA) && rd_bad;
		stat_d = stat_q;
		if (do_wr && wlane_q) begin
			// selection bytes remap later upper accesses
			if (awaddr_q == {2'h0, MMPS_ADDR_PAGE, 2'h0}) begin
				page_d = wbyte_q;
				ev[MMPS_EV_SEL_WR] = 1'b1;
			end
			if (awaddr_q == {2'h0, MMPS_ADDR_BANK, 2'h0}) begin
				bank_d = wbyte_q;
				ev[MMPS_EV_SEL_WR] = 1'b1;
			end
			if (awaddr_q == MMPS_REG_MASK) begin
				mask_d = wbyte_q[MMPS_IRQ_W-1:0];
			end
			if (awaddr_q == MMPS_REG_CTRL) begin
				hreq_d = wbyte_q[0];
			end
			if (awaddr_q == MMPS_REG_STAT) begin
				stat_d = stat_q & ~wbyte_q[MMPS_IRQ_W-1:0];
			end
		end
		stat_d = stat_d | ev;
		// module reset returns selection to page zero and drops interrupt
		if (!side.reset_n) begin
			page_d = MMPS_PAGE_RST;
			bank_d = MMPS_BANK_RST;
			hreq_d = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			page_q <= MMPS_PAGE_RST;
			bank_q <= MMPS_BANK_RST;
			mask_q <= '0;
			stat_q <= '0;
			hreq_q <= 1'b0;
		end else begin
			page_q <= page_d;
			bank_q <= bank_d;
			mask_q <= mask_d;
			stat_q <= stat_d;
			hreq_q <= hreq_d;
		end
	end

	assign irq_o = |(stat_q & mask_q);

	// read channel
	always_comb begin
		rst_d    = rst_q;
		araddr_d = araddr_q;
		rdata_d  = rdata_q;
		rresp_d  = rresp_q;
		case (rst_q)
			MMPS_R_IDLE: begin
				if (s_axi_arvalid) begin
					araddr_d = s_axi_araddr;
					rst_d    = MMPS_R_DATA;
				end
			end
			MMPS_R_DATA: begin
				rresp_d = MMPS_RESP_OKAY;
				rdata_d = 32'h0000_0000;
				if (araddr_q <= MMPS_MEM_TOP) begin
					// unsupported upper page reads as zero
					rdata_d[7:0] = rd_bad ? 8'h00 : mem_rdata;
					if (araddr_q == {2'h0, MMPS_ADDR_PAGE, 2'h0}) begin
						rdata_d[7:0] = page_q;
					end
					if (araddr_q == {2'h0, MMPS_ADDR_BANK, 2'h0}) begin
						rdata_d[7:0] = bank_q;
					end
				end else if (araddr_q == MMPS_REG_SIDE) begin
					rdata_d[2:0] = {side.irq_drive, side.lowpower_n, side.reset_n};
				end else if (araddr_q == MMPS_REG_STAT) begin
					rdata_d[MMPS_IRQ_W-1:0] = stat_q;
				end else if (araddr_q == MMPS_REG_MASK) begin
					rdata_d[MMPS_IRQ_W-1:0] = mask_q;
				end else if (araddr_q == MMPS_REG_CTRL) begin
					rdata_d[0] = hreq_q;
				end else begin
					rresp_d = MMPS_RESP_SLVE;
				end
				rst_d = MMPS_R_RESP;
			end
			MMPS_R_RESP: begin
				if (s_axi_rready) begin
					rst_d = MMPS_R_IDLE;
				end
			end
			default: rst_d = MMPS_R_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rst_q    <= MMPS_R_IDLE;
			araddr_q <= 12'h000;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= MMPS_RESP_OKAY;
		end else begin
			rst_q    <= rst_d;
			araddr_q <= araddr_d;
			rdata_q  <= rdata_d;
			rresp_q  <= rresp_d;
		end
	end

	assign s_axi_arready = (rst_q == MMPS_R_IDLE);
	assign s_axi_rvalid  = (rst_q == MMPS_R_RESP);
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
endmodule

// [verification/mmps_props.sv]
// port assertions for the paging and sideband block
`timescale 1ns/1ps
module mmps_props
	import mmps_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        irq_reset_shared_line_i,
	input wire logic        irq_reset_shared_line_oe,
	input wire logic        lowpower_present_shared_line_i,
	input wire logic        lowpower_present_shared_line_o,
	input wire logic        lowpower_present_shared_line_oe,
	input wire logic        module_side_reset_n,
	input wire logic        module_side_lowpower_n
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_reset_follows_line: assert property ($past(aresetn) |-> module_side_reset_n == $past(irq_reset_shared_line_i))
		else $error("module reset not following line");
	a_lowpower_follows_line: assert property ($past(aresetn) |->
		module_side_lowpower_n == $past(lowpower_present_shared_line_i)) else $error("low power not following line");
	a_no_irq_reset: assert property (!irq_reset_shared_line_i [*2] |=> !irq_reset_shared_line_oe)
		else $error("interrupt driven during reset");
	a_presence_pulldown: assert property (lowpower_present_shared_line_oe && !lowpower_present_shared_line_o)
		else $error("presence pull-down missing");
	a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_rvalid ##1 s_axi_rvalid)
		else $error("read answer late");
	a_write_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
		else $error("write answer late");
	a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("read upper bits set");
	a_unmapped_error: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 12'h40c
		|-> ##2 s_axi_rresp == MMPS_RESP_SLVE) else $error("unmapped read not refused");
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
	c_irq: cover property ($rose(irq_reset_shared_line_oe));
endmodule
bind mmps_top mmps_props u_props (.*);

// [verification/mmps_host_model.sv]
// host side of the two multi-level sideband lines
`timescale 1ns/1ps
module mmps_host_model (
	input wire logic  host_reset_drive_n,
	input wire logic  host_lowpower_drive_n,
	input wire logic  irq_reset_shared_line_o,
	input wire logic  irq_reset_shared_line_oe,
	input wire logic  lowpower_present_shared_line_o,
	input wire logic  lowpower_present_shared_line_oe,
	output logic      irq_reset_shared_line_i,
	output logic      lowpower_present_shared_line_i,
	output logic      host_side_irq,
	output logic      host_side_present_n
);
	logic pd;
	assign irq_reset_shared_line_i = host_reset_drive_n;
	// top zone only out of reset
	assign host_side_irq = host_reset_drive_n && irq_reset_shared_line_oe && irq_reset_shared_line_o;
	assign pd = lowpower_present_shared_line_oe && !lowpower_present_shared_line_o;
	assign lowpower_present_shared_line_i = host_lowpower_drive_n || !pd;
	assign host_side_present_n = !pd;
endmodule

// [verification/test_module_mgmt_paging_sideband.sv]
// bench for the paging and sideband block
`timescale 1ns/1ps
module test_module_mgmt_paging_sideband;
	import mmps_pkg::*;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq_o, host_side_irq, host_side_present_n;
	logic        irq_reset_shared_line_i, irq_reset_shared_line_o, irq_reset_shared_line_oe;
	logic        lowpower_present_shared_line_i, lowpower_present_shared_line_o, lowpower_present_shared_line_oe;
	logic        module_side_reset_n, module_side_lowpower_n, host_reset_drive_n, host_lowpower_drive_n;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [7:0]  pg [5] = '{8'h00, 8'h01, 8'h02, 8'h10, 8'h11};
	int          bad_count, num_checks;

	mmps_top uut (.*);
	mmps_host_model u_host (.*);

	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic guard(inout int n);
		n++;
		if (n > 50) begin
			bad_count++;
			$display("ERROR %0t bus wait timed out", $time);
			test_done;
		end
	endtask

	function automatic logic [1:0] resp(input logic [11:0] a);
		return (a > MMPS_REG_CTRL) ? MMPS_RESP_SLVE : MMPS_RESP_OKAY;
	endfunction

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		int n;
		logic ta, tw, da, dw;
		n = 0;
		da = 0;
		dw = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			#1;
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			da |= ta;
			dw |= tw;
			guard(n);
		end while (!(da && dw));
		do begin
			#1;
			ta = s_axi_bvalid;
			dw = s_axi_bresp[0];
			da = s_axi_bresp[1];
			@(posedge aclk);
			guard(n);
		end while (!ta);
		s_axi_bready <= 1'b0;
		chk({da, dw}, resp(a));
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
		int n;
		logic t;
		logic [31:0] v;
		logic [1:0] r;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			#1;
			t = s_axi_arready;
			@(posedge aclk);
			guard(n);
		end while (!t);
		s_axi_arvalid <= 1'b0;
		do begin
			#1;
			t = s_axi_rvalid;
			v = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			guard(n);
		end while (!t);
		s_axi_rready <= 1'b0;
		chk(r, resp(a));
		chk(v & m, e);
	endtask

	task automatic host(input logic r, input logic l);
		@(posedge aclk);
		host_reset_drive_n <= r;
		host_lowpower_drive_n <= l;
		repeat (4) @(posedge aclk);
		#1;
	endtask

	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		{host_reset_drive_n, host_lowpower_drive_n} = 2'b11;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		host(1, 1);
		chk({module_side_reset_n, module_side_lowpower_n, host_side_irq, host_side_present_n}, 4'hc);
		rd(MMPS_REG_SIDE, 32'h3);
		host(0, 0);
		chk({module_side_reset_n, module_side_lowpower_n, host_side_irq, host_side_present_n}, 4'h0);
		host(1, 1);
		$display("test sideband done");
		wr(MMPS_REG_CTRL, 8'h01);
		host(1, 1);
		chk({host_side_irq, irq_reset_shared_line_oe}, 2'b11);
		host(0, 1);
		chk({host_side_irq, irq_reset_shared_line_oe}, 2'b00);
		host(1, 1);
		chk(host_side_irq, 1'b0);
		$display("test interrupt line done");
		wr(12'h000, 8'h5a);
		for (int i = 0; i < 5; i++) begin
			wr({MMPS_ADDR_PAGE, 2'b00}, pg[i]);
			wr(12'h200, 8'ha0 + i[7:0]);
			wr(12'h3fc, 8'hc0 + i[7:0]);
		end
		for (int i = 0; i < 5; i++) begin
			wr({MMPS_ADDR_PAGE, 2'b00}, pg[i]);
			rd({MMPS_ADDR_PAGE, 2'b00}, {24'h0, pg[i]});
			rd(12'h200, 32'ha0 + i);
			rd(12'h3fc, 32'hc0 + i);
		end
		rd(12'h000, 32'h5a);
		wr({MMPS_ADDR_BANK, 2'b00}, 8'h01);
		rd(12'h200, 32'h0);
		wr({MMPS_ADDR_BANK, 2'b00}, 8'h00);
		rd(12'h200, 32'ha4);
		wr({MMPS_ADDR_PAGE, 2'b00}, 8'h05);
		rd(12'h200, 32'h0);
		host(0, 1);
		host(1, 1);
		rd({MMPS_ADDR_PAGE, 2'b00}, 32'h0);
		$display("test paging done");
		wr(MMPS_REG_STAT, 8'hff);
		wr(MMPS_REG_MASK, 8'h04);
		chk(irq_o, 1'b0);
		wr({MMPS_ADDR_PAGE, 2'b00}, 8'h01);
		host(1, 1);
		chk(irq_o, 1'b1);
		rd(MMPS_REG_STAT, 32'h4, 32'h4);
		wr(MMPS_REG_STAT, 8'h04);
		host(1, 1);
		chk(irq_o, 1'b0);
		wr(MMPS_REG_MASK, 8'h00);
		wr({MMPS_ADDR_PAGE, 2'b00}, 8'h00);
		host(1, 1);
		chk(irq_o, 1'b0);
		rd(MMPS_REG_MASK, 32'h0);
		wr(12'h410, 8'h11);
		rd(12'h410, 32'h0, 32'h0);
		$display("test status done");
		test_done;
	end
endmodule
